// File: rtl/itxc_tx_ctrl.sv
// control unit of a two-coil inductive power transmitter
// assumes message decoder and current sense adc run on sys_clk
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ns

module itxc_tx_ctrl #(
  parameter int PING_CYC = itxc_pkg::PING_WAIT_CYC,
  parameter int OFF_CYC = itxc_pkg::POWER_OFF_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // decoded receiver messages
  input wire logic rx_ss_valid,
  input wire logic [7:0] rx_ss_value,
  input wire logic rx_end_valid,
  // coil current sense
  input wire logic adc_valid,
  input wire logic [itxc_pkg::CUR_W-1:0] adc_code,
  // coil selection and inverter
  output logic upper_coil_switch,
  output logic lower_coil_switch,
  output itxc_pkg::itxc_bridge_t bridge,
  // base station status
  output logic power_active,
  output logic xfer_active,
  output logic [7:0] ss_value
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_SELECT, ST_PING, ST_OFF, ST_XFER} itxc_state_t;

  itxc_state_t state_r;
  itxc_state_t state_nxt;
  logic [31:0] tmr_r;
  logic coil_r;
  logic [3:0] ctrl_r;
  logic [itxc_pkg::CUR_W-1:0] target_r;
  logic [itxc_pkg::FREQ_W-1:0] step_r;
  logic [itxc_pkg::CUR_W-1:0] meas_r;
  itxc_pkg::itxc_drive_t drive_r;
  logic sw_up_r;
  logic sw_lo_r;
  logic pwr_r;
  logic xfer_r;
  logic [7:0] ss_r;
  logic [31:0] rd_r;
  logic en;
  logic two_coils;
  logic retry_en;
  itxc_pkg::itxc_mode_t mode;
  logic pid_upd;
  itxc_pkg::itxc_drive_t pid_drive;
  logic signed [19:0] pid_val;
  logic can_lower;
  itxc_pkg::itxc_bridge_t legs;

  assign en = ctrl_r[itxc_pkg::CTRL_EN_BIT];
  assign two_coils = ctrl_r[itxc_pkg::CTRL_TWO_BIT];
  assign retry_en = ctrl_r[itxc_pkg::CTRL_RETRY_BIT];
  assign mode = ctrl_r[itxc_pkg::CTRL_MODE_BIT] ? itxc_pkg::ITXC_MODE_DUTY
    : itxc_pkg::ITXC_MODE_FREQ;
  // next retry frequency must stay at or above the floor
  assign can_lower = retry_en && (step_r != '0)
    && ({1'b0, drive_r.freq_hz} >= {1'b0, itxc_pkg::FREQ_MIN_HZ} + {1'b0, step_r});

  // ****************************************************************
  // ping and transfer sequencing
  // ****************************************************************
  // next state: select, ping, remove, retry or transfer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (en) begin
          state_nxt = ST_SELECT;
        end
      end
      ST_SELECT: begin
        state_nxt = ST_PING;
      end
      ST_PING: begin
        if (rx_ss_valid) begin
          state_nxt = ST_XFER;
        end else if (tmr_r == 32'h00000000) begin
          state_nxt = ST_OFF;
        end
      end
      ST_OFF: begin
        if (tmr_r == 32'h00000000) begin
          state_nxt = ST_SELECT;
        end
      end
      ST_XFER: begin
        if (rx_end_valid) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    if (!en) begin
      state_nxt = ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ping window and power-off gap timer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tmr_r <= 32'h00000000;
    end else if (state_r == ST_SELECT) begin
      tmr_r <= 32'(PING_CYC - 1);
    end else if (state_r == ST_PING && state_nxt == ST_OFF) begin
      tmr_r <= 32'(OFF_CYC - 1);
    end else if (tmr_r != 32'h00000000) begin
      tmr_r <= tmr_r - 32'h00000001;
    end
  end

  // coil under trial: upper first, lower only when fitted
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      coil_r <= 1'b0;
    end else if (state_r == ST_IDLE || !two_coils) begin
      coil_r <= 1'b0;
    end else if (state_r == ST_OFF && state_nxt == ST_SELECT) begin
      coil_r <= !coil_r;
    end
  end

  // inverter setting: ping values, retry steps, controller updates
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drive_r.freq_hz <= itxc_pkg::PING_FREQ_HZ;
      drive_r.duty <= itxc_pkg::PING_DUTY;
    end else if (state_r == ST_IDLE) begin
      drive_r.freq_hz <= itxc_pkg::PING_FREQ_HZ;
      drive_r.duty <= itxc_pkg::PING_DUTY;
    end else if (state_r == ST_OFF && state_nxt == ST_SELECT) begin
      drive_r.duty <= itxc_pkg::PING_DUTY;
      if (two_coils && !coil_r) begin
        drive_r.freq_hz <= drive_r.freq_hz;
      end else if (can_lower) begin
        drive_r.freq_hz <= drive_r.freq_hz - step_r;
      end else begin
        drive_r.freq_hz <= itxc_pkg::PING_FREQ_HZ;
      end
    end else if (state_r == ST_XFER && pid_upd) begin
      drive_r <= pid_drive;
    end
  end

  // ****************************************************************
  // coil switches and power signal
  // ****************************************************************
  // switches only close while powered; select and off states open both
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sw_up_r <= 1'b0;
      sw_lo_r <= 1'b0;
      pwr_r <= 1'b0;
      xfer_r <= 1'b0;
    end else begin
      pwr_r <= (state_nxt == ST_PING) || (state_nxt == ST_XFER);
      sw_up_r <= ((state_nxt == ST_PING) || (state_nxt == ST_XFER)) && !coil_r;
      sw_lo_r <= ((state_nxt == ST_PING) || (state_nxt == ST_XFER)) && coil_r
        && two_coils;
      xfer_r <= state_nxt == ST_XFER;
    end
  end

  // last signal strength value reported to the base station during a ping
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ss_r <= 8'h00;
    end else if (state_r == ST_PING && rx_ss_valid) begin
      ss_r <= rx_ss_value;
    end
  end

  // coil current sample, one code per 5 mA or finer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meas_r <= '0;
    end else if (adc_valid) begin
      meas_r <= adc_code;
    end
  end

  itxc_pid u_pid (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sample_valid(adc_valid && state_r == ST_XFER),
    .meas(adc_code),
    .target(target_r),
    .mode(mode),
    .drive_in(drive_r),
    .upd(pid_upd),
    .drive_out(pid_drive),
    .pid_out(pid_val)
  );

  itxc_nco u_nco (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(pwr_r),
    .setting(drive_r),
    .legs(legs)
  );

  // ****************************************************************
  // register port
  // ****************************************************************
  // software writable settings
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= itxc_pkg::CTRL_RST;
      target_r <= itxc_pkg::TARGET_RST;
      step_r <= itxc_pkg::STEP_RST;
    end else if (wr_en) begin
      if (addr == itxc_pkg::REG_CTRL) begin
        ctrl_r <= wr_data[3:0];
      end
      if (addr == itxc_pkg::REG_TARGET) begin
        target_r <= wr_data[itxc_pkg::CUR_W-1:0];
      end
      if (addr == itxc_pkg::REG_STEP) begin
        step_r <= wr_data[itxc_pkg::FREQ_W-1:0];
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_r <= 32'h00000000;
    end else if (rd_en) begin
      case (addr)
        itxc_pkg::REG_CTRL: rd_r <= {28'h0000000, ctrl_r};
        itxc_pkg::REG_TARGET: rd_r <= {16'h0000, target_r};
        itxc_pkg::REG_STEP: rd_r <= {14'h0000, step_r};
        itxc_pkg::REG_STATUS: rd_r <= {16'h0000, ss_r, 2'b00, sw_lo_r, sw_up_r,
          pwr_r, 3'(state_r)};
        itxc_pkg::REG_FREQ: rd_r <= {14'h0000, drive_r.freq_hz};
        itxc_pkg::REG_DUTY: rd_r <= {22'h000000, drive_r.duty};
        itxc_pkg::REG_CURRENT: rd_r <= {16'h0000, meas_r};
        itxc_pkg::REG_PID: rd_r <= 32'(pid_val);
        default: rd_r <= 32'h00000000;
      endcase
    end else begin
      rd_r <= 32'h00000000;
    end
  end

  assign rd_data = rd_r;
  assign upper_coil_switch = sw_up_r;
  assign lower_coil_switch = sw_lo_r;
  assign bridge = legs;
  assign power_active = pwr_r;
  assign xfer_active = xfer_r;
  assign ss_value = ss_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_first_try;
    state_r == ST_IDLE && en ##1 state_r == ST_SELECT;
  endsequence

  sequence s_unanswered;
    state_r == ST_PING && tmr_r == 32'h00000000 && !rx_ss_valid && en;
  endsequence

  sequence s_retry;
    state_r == ST_OFF ##1 state_r == ST_SELECT;
  endsequence

  a_coil_exclusive: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(sw_up_r && sw_lo_r))
    else $error("both coil switches closed");

  a_single_coil: assert property (@(posedge sys_clk) disable iff (!nrst)
    sw_lo_r |-> $past(two_coils))
    else $error("lower coil selected while not fitted");

  a_drive_range: assert property (@(posedge sys_clk) disable iff (!nrst)
    pwr_r |-> drive_r.freq_hz >= itxc_pkg::FREQ_MIN_HZ
      && drive_r.freq_hz <= itxc_pkg::FREQ_MAX_HZ
      && drive_r.duty >= itxc_pkg::DUTY_MIN && drive_r.duty <= itxc_pkg::DUTY_MAX)
    else $error("inverter setting out of range while powered");

  a_ping_setting: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_first_try |-> drive_r.freq_hz == itxc_pkg::PING_FREQ_HZ
      && drive_r.duty == itxc_pkg::PING_DUTY ##1 pwr_r)
    else $error("first ping not at 142 kHz, 50 percent");

  a_ping_removal: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_unanswered |=> state_r == ST_OFF && !pwr_r && !sw_up_r && !sw_lo_r
      ##1 bridge == '0)
    else $error("power kept after unanswered ping");

  a_retry_lower: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_retry |-> drive_r.freq_hz <= $past(drive_r.freq_hz)
      || drive_r.freq_hz == itxc_pkg::PING_FREQ_HZ)
    else $error("retry frequency raised");

  a_pid_apply: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_r == ST_XFER && state_nxt == ST_XFER && pid_upd |=> drive_r == $past(pid_drive))
    else $error("controller result not applied");

endmodule

// File: rtl/itxc_pkg.sv
// constants, types and helpers shared by the inductive power transmitter controller
// assumes a single 50 MHz system clock

package itxc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int PING_WAIT_US = 70_000;
  localparam int POWER_OFF_US = 10_000;
  localparam int PING_WAIT_CYC = PING_WAIT_US * CLK_MHZ;
  localparam int POWER_OFF_CYC = POWER_OFF_US * CLK_MHZ;

  // ****************************************************************
  // widths and limits of the inverter drive
  // ****************************************************************
  localparam int FREQ_W = 18;
  localparam int DUTY_W = 10;
  localparam int CUR_W = 16;
  localparam int CURRENT_LSB_UA = 5000;
  localparam logic [FREQ_W-1:0] FREQ_MIN_HZ = 18'h1ADB0;  // 110 kHz
  localparam logic [FREQ_W-1:0] FREQ_MAX_HZ = 18'h320C8;  // 205 kHz
  localparam logic [FREQ_W-1:0] PING_FREQ_HZ = 18'h22AB0; // 142 kHz
  localparam logic [DUTY_W-1:0] DUTY_MIN = 10'h014;       // 2.0 %
  localparam logic [DUTY_W-1:0] DUTY_MAX = 10'h1F4;       // 50.0 %
  localparam logic [DUTY_W-1:0] PING_DUTY = 10'h1F4;      // 50.0 %
  localparam logic signed [19:0] PID_LIMIT = 20'sh04E20;  // 20,000
  // phase increment per Hz, scaled by 2^16; threshold per 0.1 %
  localparam longint INC_MUL = (64'h1 << 48) / CLK_HZ;
  localparam longint DUTY_MUL = (64'h1 << 32) / 1000;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_STEP = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_FREQ = 8'h10;
  localparam logic [7:0] REG_DUTY = 8'h14;
  localparam logic [7:0] REG_CURRENT = 8'h18;
  localparam logic [7:0] REG_PID = 8'h1C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_TWO_BIT = 2;
  localparam int CTRL_RETRY_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'hC;
  localparam logic [15:0] TARGET_RST = 16'h0000;
  localparam logic [FREQ_W-1:0] STEP_RST = 18'h007D0;    // 2 kHz

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic {ITXC_MODE_FREQ, ITXC_MODE_DUTY} itxc_mode_t;

  typedef struct packed {
    logic [FREQ_W-1:0] freq_hz;
    logic [DUTY_W-1:0] duty;
  } itxc_drive_t;

  typedef struct packed {
    logic leg_a;
    logic leg_b;
  } itxc_bridge_t;

  // limits a signed value to a window
  function automatic logic signed [19:0] itxc_clamp(logic signed [19:0] v,
      logic signed [19:0] lo, logic signed [19:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

endpackage

// File: rtl/itxc_nco.sv
// full-bridge waveform generator: phase accumulator with duty compare
// assumes frequency and duty arrive already clamped, same clock domain
`timescale 1ns/1ns

module itxc_nco (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // drive setting
  input wire logic run,
  input itxc_pkg::itxc_drive_t setting,
  // bridge legs
  output itxc_pkg::itxc_bridge_t legs
);

  // ****************************************************************
  // phase accumulation
  // ****************************************************************
  logic [31:0] phase_r;
  logic [31:0] inc;
  logic [31:0] thr;
  logic [31:0] phase_b;
  itxc_pkg::itxc_bridge_t legs_r;

  // about 0.012 Hz per increment step, 0.1 % per duty step
  assign inc = 32'((64'(setting.freq_hz) * itxc_pkg::INC_MUL) >> 16);
  assign thr = 32'(64'(setting.duty) * itxc_pkg::DUTY_MUL);
  assign phase_b = phase_r + 32'h80000000;

  // phase restarts when power is removed
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= 32'h00000000;
    end else if (!run) begin
      phase_r <= 32'h00000000;
    end else begin
      phase_r <= phase_r + inc;
    end
  end

  // leg a on first half, leg b on second half
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      legs_r <= '0;
    end else begin
      legs_r.leg_a <= run && (phase_r < thr);
      legs_r.leg_b <= run && (phase_b < thr);
    end
  end

  assign legs = legs_r;

  a_bridge_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    !run |=> legs_r == '0)
    else $error("bridge legs active while power removed");

endmodule

// File: rtl/itxc_pid.sv
// current loop controller, proportional gain one, output limited and scaled
// assumes one current sample per valid pulse, same clock domain
`timescale 1ns/1ns

module itxc_pid (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // sample and setpoint
  input wire logic sample_valid,
  input wire logic [itxc_pkg::CUR_W-1:0] meas,
  input wire logic [itxc_pkg::CUR_W-1:0] target,
  input itxc_pkg::itxc_mode_t mode,
  input itxc_pkg::itxc_drive_t drive_in,
  // result
  output logic upd,
  output itxc_pkg::itxc_drive_t drive_out,
  output logic signed [19:0] pid_out
);

  // ****************************************************************
  // error, limit and apply
  // ****************************************************************
  logic signed [19:0] err;
  logic signed [19:0] ctl;
  logic signed [19:0] f_new;
  logic signed [19:0] d_new;
  logic upd_r;
  itxc_pkg::itxc_drive_t drive_r;
  logic signed [19:0] pid_r;

  // positive error asks for more current, so more power
  assign err = 20'(signed'({1'b0, target})) - 20'(signed'({1'b0, meas}));
  assign ctl = itxc_pkg::itxc_clamp(err, -itxc_pkg::PID_LIMIT, itxc_pkg::PID_LIMIT);
  // frequency: 1 Hz per unit, lower frequency for more power
  assign f_new = itxc_pkg::itxc_clamp(20'(signed'({2'b00, drive_in.freq_hz})) - ctl,
    20'(signed'({2'b00, itxc_pkg::FREQ_MIN_HZ})),
    20'(signed'({2'b00, itxc_pkg::FREQ_MAX_HZ})));
  // duty: 0.1 % per unit, higher duty for more power
  assign d_new = itxc_pkg::itxc_clamp(20'(signed'({10'h000, drive_in.duty})) + ctl,
    20'(signed'({10'h000, itxc_pkg::DUTY_MIN})),
    20'(signed'({10'h000, itxc_pkg::DUTY_MAX})));

  // one update per sample, only the selected variable moves
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      upd_r <= 1'b0;
      drive_r <= '0;
      pid_r <= 20'sh00000;
    end else begin
      upd_r <= sample_valid;
      if (sample_valid) begin
        pid_r <= ctl;
        drive_r <= drive_in;
        if (mode == itxc_pkg::ITXC_MODE_FREQ) begin
          drive_r.freq_hz <= f_new[itxc_pkg::FREQ_W-1:0];
        end else begin
          drive_r.duty <= d_new[itxc_pkg::DUTY_W-1:0];
        end
      end
    end
  end

  assign upd = upd_r;
  assign drive_out = drive_r;
  assign pid_out = pid_r;

  a_pid_limit: assert property (@(posedge sys_clk) disable iff (!nrst)
    upd_r |-> (pid_r <= itxc_pkg::PID_LIMIT) && (pid_r >= -itxc_pkg::PID_LIMIT))
    else $error("controller output beyond limit");

  a_freq_dir: assert property (@(posedge sys_clk) disable iff (!nrst)
    sample_valid && mode == itxc_pkg::ITXC_MODE_FREQ && err > 0
      |=> drive_r.freq_hz <= $past(drive_in.freq_hz))
    else $error("frequency raised while current below target");

  a_drive_clamp: assert property (@(posedge sys_clk) disable iff (!nrst)
    upd_r |-> drive_r.freq_hz >= itxc_pkg::FREQ_MIN_HZ
      && drive_r.freq_hz <= itxc_pkg::FREQ_MAX_HZ
      && drive_r.duty >= itxc_pkg::DUTY_MIN && drive_r.duty <= itxc_pkg::DUTY_MAX)
    else $error("updated drive outside permitted range");

endmodule

// File: verif/itxc_rx_model.sv
// receiver model: answers a ping on a chosen coil with one strength packet
// assumes the controller's coil and power outputs on the same sys_clk
`timescale 1ns/1ns

module itxc_rx_model #(
  parameter int DELAY = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // what the transmitter applies
  input wire logic power_active,
  input wire logic upper_coil_switch,
  input wire logic lower_coil_switch,
  // where the receiver sits, what it reports
  input wire logic on_upper,
  input wire logic on_lower,
  input wire logic [7:0] strength,
  // decoded packet
  output logic rx_ss_valid,
  output logic [7:0] rx_ss_value
);
  int cnt_r;
  logic hit;

  // coupled only while the powered coil lies under the receiver
  assign hit = power_active & ((upper_coil_switch & on_upper) | (lower_coil_switch & on_lower));

  // cycles into the ping, restarts whenever power goes away
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= hit ? cnt_r + 1 : 0;
    end
  end

  // one packet per ping; value scrambled outside the strobe
  always_comb begin
    rx_ss_valid = hit && (cnt_r == DELAY);
    rx_ss_value = rx_ss_valid ? strength : ~strength;
  end
endmodule

// File: verif/testbench.sv
// self-checking bench for the transmitter controller
// assumes itxc_pkg, itxc_tx_ctrl and itxc_rx_model are compiled first
`timescale 1ns/1ns

module testbench;
  logic sys_clk, nrst, wr_en, rd_en, rx_end_valid, adc_valid, on_upper, on_lower;
  logic rx_ss_valid, upper_coil_switch, lower_coil_switch, power_active, xfer_active;
  logic seen_a, seen_low;
  logic [7:0] addr, rx_ss_value, ss_value;
  logic [31:0] wr_data, rd_data, d;
  logic [15:0] adc_code;
  itxc_pkg::itxc_bridge_t bridge;
  int n_mismatch, n_checks;

  itxc_tx_ctrl #(.PING_CYC(200), .OFF_CYC(50)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .rx_ss_valid(rx_ss_valid), .rx_ss_value(rx_ss_value), .rx_end_valid(rx_end_valid),
    .adc_valid(adc_valid), .adc_code(adc_code), .upper_coil_switch(upper_coil_switch),
    .lower_coil_switch(lower_coil_switch), .bridge(bridge), .power_active(power_active),
    .xfer_active(xfer_active), .ss_value(ss_value));

  itxc_rx_model #(.DELAY(20)) rx (.sys_clk(sys_clk), .nrst(nrst),
    .power_active(power_active), .upper_coil_switch(upper_coil_switch),
    .lower_coil_switch(lower_coil_switch), .on_upper(on_upper), .on_lower(on_lower),
    .strength(8'hA5), .rx_ss_valid(rx_ss_valid), .rx_ss_value(rx_ss_value));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  // bounded wait on power (x=0) or transfer (x=1) reaching a level
  task automatic wt(input logic want, input bit x);
    for (int i = 0; i < 400 && (x ? xfer_active : power_active) !== want; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(x ? xfer_active : power_active, want);
  endtask

  task automatic adc(input logic [15:0] v);
    @(posedge sys_clk);
    adc_valid <= 1'b1;
    adc_code <= v;
    @(posedge sys_clk);
    adc_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rdc(8'h00, 32'h0000000C);
    chk({upper_coil_switch, lower_coil_switch, bridge, power_active, xfer_active, ss_value}, 0);
    rdc(8'h08, 32'h000007D0);
    rdc(8'h04, 32'h00000000);
    rdc(8'h20, 32'h00000000);
    rdc(8'h0C, 32'h00000000);
  endtask

  task automatic t_retry;
    seen_a = 1'b0;
    wr(8'h00, 32'h0000000D);
    wt(1'b1, 0);
    chk({upper_coil_switch, lower_coil_switch}, 2'b10);
    rdc(8'h10, 32'h00022AB0);
    rdc(8'h14, 32'h000001F4);
    wt(1'b0, 0);
    chk({seen_a, upper_coil_switch, lower_coil_switch}, 3'b100);
    wt(1'b1, 0);
    chk({upper_coil_switch, lower_coil_switch}, 2'b01);
    wt(1'b0, 0);
    wt(1'b1, 0);
    chk(upper_coil_switch, 1'b1);
    rdc(8'h10, 32'h000222E0);
    wr(8'h00, 32'h0000000C);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(power_active, 1'b0);
  endtask

  task automatic t_single;
    seen_low = 1'b0;
    wr(8'h00, 32'h00000001);
    wt(1'b1, 0);
    wt(1'b0, 0);
    wt(1'b1, 0);
    chk({seen_low, upper_coil_switch}, 2'b01);
    rdc(8'h10, 32'h00022AB0);
    wr(8'h00, 32'h0000000C);
  endtask

  task automatic t_xfer;
    on_lower <= 1'b1;
    wr(8'h00, 32'h0000000D);
    wt(1'b1, 1);
    chk({upper_coil_switch, lower_coil_switch, ss_value}, 10'h1A5);
    rdc(8'h0C, 32'h0000A52C);
    wr(8'h04, 32'h0000FFFF);
    adc(16'h0000);
    rdc(8'h10, 32'h0001DC90);
    adc(16'h0000);
    rdc(8'h10, 32'h0001ADB0);
    rdc(8'h1C, 32'h00004E20);
    wr(8'h04, 32'h00000000);
    adc(16'h0003);
    rdc(8'h10, 32'h0001ADB3);
    wr(8'h00, 32'h0000000F);
    adc(16'h0258);
    rdc(8'h14, 32'h00000014);
    rdc(8'h18, 32'h00000258);
    wr(8'h04, 32'h00000005);
    adc(16'h0000);
    rdc(8'h14, 32'h00000019);
    @(posedge sys_clk);
    rx_end_valid <= 1'b1;
    @(posedge sys_clk);
    rx_end_valid <= 1'b0;
    wt(1'b0, 1);
    wr(8'h00, 32'h0000000C);
    on_lower <= 1'b0;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // clock, monitor, watchdog, main sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // coil exclusivity and leg overlap watched every cycle
  always @(posedge sys_clk) begin
    if (upper_coil_switch === 1'b1 && lower_coil_switch === 1'b1) chk(1, 0);
    if (bridge.leg_a === 1'b1 && bridge.leg_b === 1'b1) chk(1, 0);
    if (bridge.leg_a === 1'b1) seen_a = 1'b1;
    if (lower_coil_switch === 1'b1) seen_low = 1'b1;
  end

  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end

  initial begin
    {nrst, wr_en, rd_en, rx_end_valid, adc_valid, on_upper, on_lower} = '0;
    {addr, wr_data, adc_code, seen_a, seen_low} = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_retry();
    t_single();
    t_xfer();
    close_out();
  end
endmodule
